// ===== design/otfs_pkg.sv
// Constants shared by the overcurrent and thermal fault status block
package otfs_pkg;
   // Command codes of the status bytes on the management bus
   localparam logic [7:0] OTFS_ADDR_OC_THERMAL = 8'hd5;
   localparam logic [7:0] OTFS_ADDR_PERSIST = 8'hd6;
   localparam logic [7:0] OTFS_ADDR_LOC_ONE = 8'hd9;
   localparam logic [7:0] OTFS_ADDR_LOC_TWO = 8'hda;
   // Reset values
   localparam logic [7:0] OTFS_RST_OC_THERMAL = 8'h00;
   localparam logic [7:0] OTFS_RST_PERSIST = 8'h00;
   localparam logic [7:0] OTFS_RST_LOC = 8'h00;
   // Field positions of the overcurrent and thermal byte
   localparam int OTFS_B_OC_ONE = 0;
   localparam int OTFS_B_OC_TWO = 1;
   localparam int OTFS_B_NEG_OC = 2;
   localparam int OTFS_B_CCL = 4;
   localparam int OTFS_B_AVG = 5;
   localparam int OTFS_B_THERMAL = 7;
   // Field positions of the persistent byte
   localparam int OTFS_B_PERSIST_OC_TWO = 2;
   localparam int OTFS_B_PERSIST_NEG_OC = 4;
   // Bits that hold a value; all others are reserved and read zero
   localparam logic [7:0] OTFS_MASK_OC_THERMAL = 8'hb7;
   localparam logic [7:0] OTFS_MASK_PERSIST = 8'h14;
   // Sticky bits of the first byte; the loop-mode bit is live status
   localparam logic [7:0] OTFS_STICKY_OC_THERMAL = 8'ha7;
   // Consecutive cycles a condition may last before it is persistent
   localparam int OTFS_PERSIST_CYCLES = 3;
   localparam logic [2:0] OTFS_PERSIST_CNT = 3'(OTFS_PERSIST_CYCLES);
endpackage : otfs_pkg

// ===== design/otfs_status.sv
// Overcurrent and thermal fault status bytes with persistence shutdown
// Operation
// - Level-one overcurrent at any phase sets bit 0
// - Level-one phase recorded in location byte 0xd9
// - Level-two overcurrent at any phase sets bit 1
// - Level-two phase recorded in location byte 0xda
// - Negative overcurrent at any phase sets bit 2
// - Negative overcurrent phase also recorded in 0xd9
// - Bit 4 shows live constant-current loop mode
// - Average current protection fault sets bit 5
// - Thermal shutdown trip sets bit 7
// - Reserved bits always read zero
// - Both bytes host accessible, reset to zero
// - Level-two over three cycles: switches off, bit 2
// - Negative over three cycles: switches off, bit 4
`timescale 1ns/1ns
`default_nettype none
module otfs_status
   import otfs_pkg::*;
#(
   parameter int NUM_PHASES = 6
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [NUM_PHASES-1:0] i_oc_one_phase,
   input wire logic [NUM_PHASES-1:0] i_oc_two_phase,
   input wire logic [NUM_PHASES-1:0] i_neg_oc_phase,
   input wire logic i_ccl_active,
   input wire logic i_avg_fault,
   input wire logic i_thermal_trip,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_switch_off
);
   // Whole state of the block
   typedef struct packed {
      logic [7:0] oc_thermal; // First status byte
      logic [7:0] persist; // Second status byte
      logic [NUM_PHASES-1:0] loc_one; // Phases of level-one or negative events
      logic [NUM_PHASES-1:0] loc_two; // Phases of level-two events
      logic [2:0] cnt_two; // Consecutive level-two cycles
      logic [2:0] cnt_neg; // Consecutive negative cycles
      logic [7:0] rdata; // Read answer
      logic rvalid; // Read answer strobe
      logic switch_off; // Power switch shutdown
   } otfs_state_s;

   otfs_state_s st; // Registered state
   otfs_state_s next_st; // Next state

   // Saturating run length of a condition
   function automatic logic [2:0] otfs_run(input logic cond, input logic [2:0] cnt);
      if (!cond) begin
         return 3'h0;
      end
      return (cnt == OTFS_PERSIST_CNT) ? cnt : 3'(cnt + 3'h1);
   endfunction : otfs_run

   // Write strobe aimed at one command code
   function automatic logic otfs_wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] o);
      return wr && (a == o);
   endfunction : otfs_wr_hit

   logic any_oc_one; // Level-one anywhere
   logic any_oc_two; // Level-two anywhere
   logic any_neg; // Negative anywhere
   logic [7:0] set_oc; // Events into the first byte
   logic [7:0] set_persist; // Events into the second byte
   logic [7:0] clr_oc; // Host clears of the first byte
   logic [7:0] clr_persist; // Host clears of the second byte

   // Event and clear vectors
   always_comb begin
      any_oc_one = |i_oc_one_phase;
      any_oc_two = |i_oc_two_phase;
      any_neg = |i_neg_oc_phase;
      set_oc = 8'h00;
      set_oc[OTFS_B_OC_ONE] = any_oc_one;
      set_oc[OTFS_B_OC_TWO] = any_oc_two;
      set_oc[OTFS_B_NEG_OC] = any_neg;
      set_oc[OTFS_B_AVG] = i_avg_fault;
      set_oc[OTFS_B_THERMAL] = i_thermal_trip;
      set_persist = 8'h00;
      // Flag the fourth consecutive cycle, i.e. more than three
      set_persist[OTFS_B_PERSIST_OC_TWO] = any_oc_two && (st.cnt_two == OTFS_PERSIST_CNT);
      set_persist[OTFS_B_PERSIST_NEG_OC] = any_neg && (st.cnt_neg == OTFS_PERSIST_CNT);
      // Write one to clear; a plain overwrite could set a flag by software
      clr_oc = otfs_wr_hit(i_reg_wr, i_reg_addr, OTFS_ADDR_OC_THERMAL) ? i_reg_wdata : 8'h00;
      clr_persist = otfs_wr_hit(i_reg_wr, i_reg_addr, OTFS_ADDR_PERSIST) ? i_reg_wdata : 8'h00;
   end

   // Next-state logic
   always_comb begin
      next_st = st;
      // Set wins over a clear in the same cycle so no event is lost
      next_st.oc_thermal = ((st.oc_thermal & ~clr_oc) | set_oc) & OTFS_STICKY_OC_THERMAL;
      next_st.oc_thermal[OTFS_B_CCL] = i_ccl_active;
      next_st.persist = ((st.persist & ~clr_persist) | set_persist) & OTFS_MASK_PERSIST;
      // Location bytes clear with their own writes, like the flags
      if (otfs_wr_hit(i_reg_wr, i_reg_addr, OTFS_ADDR_LOC_ONE)) begin
         next_st.loc_one = st.loc_one & ~i_reg_wdata[NUM_PHASES-1:0];
      end
      if (otfs_wr_hit(i_reg_wr, i_reg_addr, OTFS_ADDR_LOC_TWO)) begin
         next_st.loc_two = st.loc_two & ~i_reg_wdata[NUM_PHASES-1:0];
      end
      next_st.loc_one = next_st.loc_one | i_oc_one_phase | i_neg_oc_phase;
      next_st.loc_two = next_st.loc_two | i_oc_two_phase;
      next_st.cnt_two = otfs_run(any_oc_two, st.cnt_two);
      next_st.cnt_neg = otfs_run(any_neg, st.cnt_neg);
      // Switches stay off while either persistent flag is held
      next_st.switch_off = |next_st.persist;
      // Read answer one cycle after the strobe
      next_st.rvalid = i_reg_rd;
      next_st.rdata = st.rdata;
      if (i_reg_rd) begin
         case (i_reg_addr)
            OTFS_ADDR_OC_THERMAL: begin
               next_st.rdata = st.oc_thermal & OTFS_MASK_OC_THERMAL;
            end
            OTFS_ADDR_PERSIST: begin
               next_st.rdata = st.persist & OTFS_MASK_PERSIST;
            end
            OTFS_ADDR_LOC_ONE: begin
               next_st.rdata = 8'(st.loc_one);
            end
            OTFS_ADDR_LOC_TWO: begin
               next_st.rdata = 8'(st.loc_two);
            end
            default: begin
               // Unmapped codes answer zero
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   // State register, synchronous reset
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st.oc_thermal <= OTFS_RST_OC_THERMAL;
         st.persist <= OTFS_RST_PERSIST;
         st.loc_one <= OTFS_RST_LOC[NUM_PHASES-1:0];
         st.loc_two <= OTFS_RST_LOC[NUM_PHASES-1:0];
         st.cnt_two <= 3'h0;
         st.cnt_neg <= 3'h0;
         st.rdata <= 8'h00;
         st.rvalid <= 1'b0;
         st.switch_off <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign o_reg_rdata = st.rdata;
   assign o_reg_rvalid = st.rvalid;
   assign o_switch_off = st.switch_off;

   default clocking otfs_cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   // Four consecutive cycles of a condition
   sequence s_two_held;
      any_oc_two [*4];
   endsequence
   sequence s_neg_held;
      any_neg [*4];
   endsequence

   // Each event flag and its phase location one cycle after the event
   a_oc_one_set: assert property (any_oc_one |=> st.oc_thermal[OTFS_B_OC_ONE])
      else $error("level-one flag not set");
   a_loc_one_rec: assert property (any_oc_one |=> (st.loc_one & $past(i_oc_one_phase))
      == $past(i_oc_one_phase))
      else $error("level-one phase not recorded");
   a_oc_two_set: assert property (any_oc_two |=> st.oc_thermal[OTFS_B_OC_TWO])
      else $error("level-two flag not set");
   a_loc_two_rec: assert property (any_oc_two |=> (st.loc_two & $past(i_oc_two_phase))
      == $past(i_oc_two_phase))
      else $error("level-two phase not recorded");
   a_neg_set_rec: assert property (any_neg |=> st.oc_thermal[OTFS_B_NEG_OC]
      && ((st.loc_one & $past(i_neg_oc_phase)) == $past(i_neg_oc_phase)))
      else $error("negative flag or phase missing");
   // Live loop-mode bit follows its input with one flop of delay
   a_ccl_live: assert property (##1 st.oc_thermal[OTFS_B_CCL] == $past(i_ccl_active))
      else $error("loop mode bit wrong");
   a_avg_set: assert property (i_avg_fault |=> st.oc_thermal[OTFS_B_AVG])
      else $error("average flag not set");
   a_therm_set: assert property (i_thermal_trip |=> st.oc_thermal[OTFS_B_THERMAL])
      else $error("thermal flag not set");
   a_reserved_zero: assert property (((st.oc_thermal & ~OTFS_MASK_OC_THERMAL) == 8'h00)
      && ((st.persist & ~OTFS_MASK_PERSIST) == 8'h00))
      else $error("reserved bit set");
   // Read path answers with the value held at the strobe edge
   a_read_answer: assert property ((i_reg_rd && i_reg_addr == OTFS_ADDR_PERSIST) |=>
      o_reg_rvalid && o_reg_rdata == $past(st.persist))
      else $error("read answer wrong");
   // Four edges trip persistence, three do not; switches drop in the same cycle
   a_two_persist: assert property (s_two_held |=> st.persist[OTFS_B_PERSIST_OC_TWO]
      && o_switch_off)
      else $error("persistent level-two not latched");
   a_two_early: assert property (!st.persist[OTFS_B_PERSIST_OC_TWO] && !any_oc_two
      ##1 any_oc_two [*3] |=> !st.persist[OTFS_B_PERSIST_OC_TWO])
      else $error("persistent level-two set too early");
   a_neg_persist: assert property (s_neg_held |=> st.persist[OTFS_B_PERSIST_NEG_OC]
      && o_switch_off)
      else $error("persistent negative not latched");
   // Shutdown output mirrors the persistent flags, so a host clear releases it
   a_switch_match: assert property (o_switch_off == (st.persist != 8'h00))
      else $error("switch shutdown does not match persistent flags");
   // Sticky flag survives the end of its condition
   a_flag_sticky: assert property ((st.oc_thermal[OTFS_B_THERMAL] && !i_thermal_trip
      && !(i_reg_wr && i_reg_addr == OTFS_ADDR_OC_THERMAL)) |=>
      st.oc_thermal[OTFS_B_THERMAL])
      else $error("thermal flag lost without clear");
endmodule : otfs_status
`default_nettype wire

// ===== sim/otfs_host_model.sv
// Host model that issues byte reads and writes on the status command port
`timescale 1ns/1ns
`default_nettype none
module otfs_host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic [7:0] o_reg_addr,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_rd
);
   // Idle on an unmapped command with no strobe
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd = 1'b0;
   end
   // One read; the answer is taken at the edge that shows the valid pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      o_reg_addr <= a;
      o_reg_rd <= 1'b1;
      @(posedge i_core_clk);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~a;
      // Bounded wait, so a dead answer cannot hang the host
      do begin
         @(posedge i_core_clk);
         n++;
      end while (i_reg_rvalid !== 1'b1 && n < 4);
      d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
   endtask : rd
   // One write; ones in the data clear the matching flags
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      o_reg_addr <= a;
      o_reg_wdata <= d;
      o_reg_wr <= 1'b1;
      @(posedge i_core_clk);
      o_reg_wr <= 1'b0;
      o_reg_addr <= ~a;
      o_reg_wdata <= ~d;
   endtask : wr
endmodule : otfs_host_model
`default_nettype wire

// ===== sim/tb_otfs_status.sv
// Self-checking bench for the fault status bytes
`timescale 1ns/1ns
`default_nettype none
module tb_otfs_status import otfs_pkg::*;;
   logic i_core_clk;
   logic i_rst;
   logic [5:0] p1, p2, pn; // Per-phase fault levels
   logic constant_current_loop, avg, therm;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, rvalid, sw_off;
   int mismatches;
   int tests_run;
   // Table of single faults: inputs, status byte, location byte
   logic [5:0] t1 [5] = '{6'h08, 6'h00, 6'h00, 6'h00, 6'h00};
   logic [5:0] t2 [5] = '{6'h00, 6'h20, 6'h00, 6'h00, 6'h00};
   logic [5:0] tn [5] = '{6'h00, 6'h00, 6'h02, 6'h00, 6'h00};
   logic [2:0] tm [5] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h4};
   logic [7:0] ts [5] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h80};
   logic [7:0] ta [5] = '{8'hd9, 8'hda, 8'hd9, 8'hd9, 8'hda};
   logic [7:0] tl [5] = '{8'h08, 8'h20, 8'h02, 8'h00, 8'h00};
   otfs_status i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_oc_one_phase(p1),
      .i_oc_two_phase(p2), .i_neg_oc_phase(pn), .i_ccl_active(constant_current_loop), .i_avg_fault(avg),
      .i_thermal_trip(therm), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_switch_off(sw_off));
   otfs_host_model i_host (.i_core_clk(i_core_clk), .i_reg_rdata(rdata),
      .i_reg_rvalid(rvalid), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata),
      .o_reg_rd(rd));
   // 125 MHz clock
   initial begin
      i_core_clk = 1'b0;
      forever #4 i_core_clk = ~i_core_clk;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      chk(nm, e, d);
   endtask : rchk
   // Hold fault levels for n sampling edges, then drop them
   task automatic fault(input logic [5:0] a, b, c, input logic [2:0] m, input int n);
      @(posedge i_core_clk);
      {p1, p2, pn, therm, avg} <= {a, b, c, m[2:1]};
      repeat (n) @(posedge i_core_clk);
      {p1, p2, pn, therm, avg} <= '0;
   endtask : fault
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // Watchdog well beyond the expected run length
   initial begin
      #(8 * 4000);
      mismatches++;
      close_out();
   end
   initial begin
      {p1, p2, pn, constant_current_loop, avg, therm} = '0;
      mismatches = 0;
      tests_run = 0;
      i_rst = 1'b1;
      repeat (4) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rchk("status", OTFS_ADDR_OC_THERMAL, OTFS_RST_OC_THERMAL);
      rchk("persist", OTFS_ADDR_PERSIST, OTFS_RST_PERSIST);
      rchk("unmapped", 8'hd7, 8'h00);
      $display("test reset done");
      // Each one-cycle fault must still read back after it is gone
      for (int i = 0; i < 5; i++) begin
         fault(t1[i], t2[i], tn[i], tm[i], 1);
         rchk("status", OTFS_ADDR_OC_THERMAL, ts[i]);
         rchk("location", ta[i], tl[i]);
         i_host.wr(OTFS_ADDR_OC_THERMAL, 8'hff);
         i_host.wr(ta[i], 8'hff);
         rchk("cleared", OTFS_ADDR_OC_THERMAL, 8'h00);
      end
      $display("test single faults done");
      // Three edges is not persistent; four edges is
      fault(6'h00, 6'h01, 6'h00, 3'h0, 3);
      rchk("short", OTFS_ADDR_PERSIST, 8'h00);
      chk("switch short", 8'h00, {7'h00, sw_off});
      fault(6'h00, 6'h01, 6'h00, 3'h0, 4);
      fault(6'h00, 6'h00, 6'h04, 3'h0, 4);
      rchk("long", OTFS_ADDR_PERSIST, 8'h14);
      chk("switch long", 8'h01, {7'h00, sw_off});
      i_host.wr(OTFS_ADDR_PERSIST, 8'hff);
      rchk("persist clr", OTFS_ADDR_PERSIST, 8'h00);
      chk("switch clr", 8'h00, {7'h00, sw_off});
      $display("test persistence done");
      // Loop-mode bit is live status
      @(posedge i_core_clk);
      constant_current_loop <= 1'b1;
      rchk("loop on", OTFS_ADDR_OC_THERMAL, 8'h16);
      @(posedge i_core_clk);
      constant_current_loop <= 1'b0;
      rchk("loop off", OTFS_ADDR_OC_THERMAL, 8'h06);
      $display("test loop mode done");
      close_out();
   end
endmodule : tb_otfs_status
`default_nettype wire
